// ===== rtl/awp_defines.svh
// Constants for the write address port: widths, codes and reset values
`ifndef AWP_DEFINES_SVH
`define AWP_DEFINES_SVH
`define AWP_ADDR_W      32
`define AWP_ID_W        4
`define AWP_DATA_W      32
`define AWP_STRB_W      4
`define AWP_LEN_W       8
`define AWP_SIZE_W      3
`define AWP_BURST_W     2
`define AWP_BURST_FIXED 2'h0
`define AWP_BURST_INCR  2'h1
`define AWP_BURST_WRAP  2'h2
`define AWP_ECC_EN      1'h0
`define AWP_FLAG_RST    1'h0
`endif

// ===== rtl/awp_pkg.sv
// Types shared by the write address port modules
`default_nettype none
package awp_pkg;
   typedef enum logic [2:0] {
      AWP_IDLE = 3'b001,
      AWP_BURST = 3'b010,
      AWP_LASTBEAT = 3'b100
   } awp_state_t;
endpackage
`default_nettype wire

// ===== rtl/awp_beat_if.sv
// Beat address carrier between the port and its address generator
`timescale 1ns/1ps
`default_nettype none
`include "awp_defines.svh"
interface awp_beat_if;
   logic [`AWP_ADDR_W-1:0]  addr;
   logic [`AWP_SIZE_W-1:0]  size;
   logic [`AWP_BURST_W-1:0] burst;
   logic [`AWP_LEN_W-1:0]   len;
   logic [`AWP_ADDR_W-1:0]  nextAddr;
   modport port (output addr, output size, output burst, output len, input nextAddr);
   modport gen  (input addr, input size, input burst, input len, output nextAddr);
endinterface
`default_nettype wire

// ===== rtl/awp_addr_gen.sv
// Next beat address from the burst type, size and length
`timescale 1ns/1ps
`default_nettype none
`include "awp_defines.svh"
module awp_addr_gen (
   awp_beat_if.gen b
);
   logic [`AWP_ADDR_W-1:0] step;
   logic [`AWP_ADDR_W-1:0] wrapMask;
   logic [`AWP_ADDR_W-1:0] incr;
   always_comb
   begin
      step = `AWP_ADDR_W'(1) << b.size;
      // Wrap span is beats times size; legal wrap lengths are powers of two
      wrapMask = ((`AWP_ADDR_W'(b.len) + `AWP_ADDR_W'(1)) << b.size) - `AWP_ADDR_W'(1);
      incr = b.addr + step;
      // Fixed is handled as incrementing, the array has no fifo mode
      if (b.burst == `AWP_BURST_WRAP) // see [RULE6]
         b.nextAddr = (b.addr & ~wrapMask) | (incr & wrapMask);
      else
         b.nextAddr = (b.addr & ~(step - `AWP_ADDR_W'(1))) + step; // see [RULE6]
   end
endmodule
`default_nettype wire

// ===== rtl/awp_write_port.sv
// Write address port: accepts addresses, walks the burst and emits per-beat strobes
// Overview of operation
// [RULE1] Reset is taken active low and returns all channel state to its initial value.
// [RULE2] The error interrupt output leaves reset low and stays low as error correction is off.
// [RULE3] The uncorrectable error flag leaves reset low and stays low as error correction is off.
// [RULE4] The length field plus one is the exact number of data beats for the address.
// [RULE5] The size field sets each beat's size and only strobed byte lanes are written.
// [RULE6] Each beat address follows from the burst type together with the size.
// [RULE7] Lock, cache and protection inputs are accepted and their values ignored.
// [RULE8] The master raises address valid only when an address is presented.
// [RULE9] The master holds the address and controls stable until ready is seen.
// [RULE10] Address ready marks acceptance and is low out of reset.
// [RULE11] Strobe bit n enables data bits 8n+7 down to 8n.
// [RULE12] Everything is sampled on the rising clock edge and a transfer completes on valid and ready.
`timescale 1ns/1ps
`default_nettype none
`include "awp_defines.svh"
module awp_write_port (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  wire logic                     clkEn,
   input  wire logic                     aresetN,
   input  wire logic [`AWP_ID_W-1:0]     awId,
   input  wire logic [`AWP_ADDR_W-1:0]   awAddr,
   input  wire logic [`AWP_LEN_W-1:0]    awLen,
   input  wire logic [`AWP_SIZE_W-1:0]   awSize,
   input  wire logic [`AWP_BURST_W-1:0]  awBurst,
   input  wire logic [2:0]               awLock,
   input  wire logic [4:0]               awCache,
   input  wire logic [3:0]               awProt,
   input  wire logic                     awValid,
   input  wire logic [`AWP_DATA_W-1:0]   wData,
   input  wire logic [`AWP_STRB_W-1:0]   wStrb,
   input  wire logic                     wValid,
   output logic                          awReady,
   output logic                          wReady,
   output logic                          memWe,
   output logic [`AWP_ADDR_W-1:0]        memAddr,
   output logic [`AWP_DATA_W-1:0]        memData,
   output logic [`AWP_DATA_W-1:0]        memBitEn,
   output logic                          burstDone,
   output logic [`AWP_ID_W-1:0]          doneId,
   output logic                          eccInterrupt,
   output logic                          uncorrectable_error_flag
);
   awp_beat_if b ();
   awp_addr_gen u_gen (.b(b));

   awp_pkg::awp_state_t   state_q;
   logic [`AWP_ADDR_W-1:0] addr_q;
   logic [`AWP_SIZE_W-1:0] size_q;
   logic [`AWP_BURST_W-1:0] burst_q;
   logic [`AWP_LEN_W-1:0]  len_q;
   logic [`AWP_LEN_W-1:0]  left_q;
   logic [`AWP_ID_W-1:0]   id_q;
   logic                   rst;
   logic                   awFire;
   logic                   wFire;
   logic [`AWP_DATA_W-1:0] laneMask;

   // Either reset source clears the port; the low-active one is the bus reset
   assign rst = reset | ~aresetN; // see [RULE1]
   // Attribute inputs are deliberately left unread, no atomic or cache behaviour exists
   assign awFire = awValid & awReady; // see [RULE12]
   assign wFire = wValid & wReady; // see [RULE12]
   assign b.addr = addr_q;
   assign b.size = size_q;
   assign b.burst = burst_q;
   assign b.len = len_q;

   always_comb
   begin
      for (int n = 0; n < `AWP_STRB_W; n++)
         laneMask[8*n +: 8] = {8{wStrb[n]}}; // see [RULE11]
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_q <= awp_pkg::AWP_IDLE;
         awReady <= 1'h0; // see [RULE10]
         wReady <= 1'h0;
         left_q <= `AWP_LEN_W'(0);
      end
      else if (clkEn)
      begin
         case (state_q)
            awp_pkg::AWP_IDLE:
            begin
               awReady <= ~awFire;
               if (awFire) // see [RULE10]
               begin
                  left_q <= awLen; // see [RULE4]
                  wReady <= 1'h1;
                  state_q <= (awLen == `AWP_LEN_W'(0)) ? awp_pkg::AWP_LASTBEAT
                                                        : awp_pkg::AWP_BURST;
               end
            end
            awp_pkg::AWP_BURST:
               if (wFire)
               begin
                  left_q <= left_q - `AWP_LEN_W'(1); // see [RULE4]
                  if (left_q == `AWP_LEN_W'(1))
                     state_q <= awp_pkg::AWP_LASTBEAT;
               end
            awp_pkg::AWP_LASTBEAT:
               if (wFire)
               begin
                  wReady <= 1'h0;
                  awReady <= 1'h1;
                  state_q <= awp_pkg::AWP_IDLE;
               end
            default:
            begin
               state_q <= awp_pkg::AWP_IDLE;
               awReady <= 1'h0;
               wReady <= 1'h0;
            end
         endcase
      end
   end

   // Captured controls; held stable for the master by the handshake
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         addr_q <= `AWP_ADDR_W'(0);
         size_q <= `AWP_SIZE_W'(0);
         burst_q <= `AWP_BURST_W'(0);
         len_q <= `AWP_LEN_W'(0);
         id_q <= `AWP_ID_W'(0);
      end
      else if (clkEn)
      begin
         if (awFire) // see [RULE7] [RULE9]
         begin
            addr_q <= awAddr;
            size_q <= awSize; // see [RULE5]
            burst_q <= awBurst; // see [RULE6]
            len_q <= awLen;
            id_q <= awId;
         end
         else if (wFire)
            addr_q <= b.nextAddr; // see [RULE6]
      end
   end

   // Memory write beat, one cycle after the data handshake
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         memWe <= 1'h0;
         memAddr <= `AWP_ADDR_W'(0);
         memData <= `AWP_DATA_W'(0);
         memBitEn <= `AWP_DATA_W'(0);
         burstDone <= 1'h0;
         doneId <= `AWP_ID_W'(0);
      end
      else if (clkEn)
      begin
         memWe <= wFire;
         burstDone <= wFire && (state_q == awp_pkg::AWP_LASTBEAT);
         if (wFire)
         begin
            memAddr <= addr_q;
            memData <= wData;
            memBitEn <= laneMask; // see [RULE5]
            doneId <= id_q;
         end
      end
   end

   // Error correction is not built in, so both flags stay at their reset level
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         eccInterrupt <= `AWP_FLAG_RST; // see [RULE2]
         uncorrectable_error_flag <= `AWP_FLAG_RST; // see [RULE3]
      end
      else if (clkEn)
      begin
         eccInterrupt <= `AWP_ECC_EN & eccInterrupt; // see [RULE2]
         uncorrectable_error_flag <= `AWP_ECC_EN & uncorrectable_error_flag; // see [RULE3]
      end
   end

   chk_ready_low_reset: assert property (@(posedge clk_sys) // see [RULE10]
      $past(rst) |-> !awReady) else $error("address ready high after reset");
   chk_ecc_flags_low: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE2] [RULE3]
      !eccInterrupt && !uncorrectable_error_flag) else $error("ecc flag raised");
   chk_no_reaccept_burst: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE4]
      awFire && clkEn |=> !awReady) else $error("address accepted mid burst");
   chk_beat_count: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE4]
      awFire && clkEn |=> left_q == $past(awLen)) else $error("beat count wrong");
   chk_capture_addr: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE12]
      awFire && clkEn |=> addr_q == $past(awAddr)) else $error("address not captured");
   chk_lane_mask: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE11]
      wFire && clkEn |=> memBitEn[7:0] == {8{$past(wStrb[0])}}) else $error("lane 0 mask");
   chk_incr_step: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE6]
      wFire && clkEn && burst_q == `AWP_BURST_INCR && size_q == 3'h2 && addr_q[1:0] == 2'h0
      |=> addr_q == $past(addr_q) + 32'h0000_0004) else $error("incr step wrong");
   chk_write_beat: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE5]
      wFire && clkEn |=> memWe && memData == $past(wData)) else $error("beat not written");
   chk_last_ready: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE10]
      wFire && clkEn && state_q == awp_pkg::AWP_LASTBEAT |=> awReady && burstDone)
      else $error("no ready after last beat");
   chk_no_beat_idle: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE4]
      state_q == awp_pkg::AWP_IDLE |-> !wReady) else $error("beat ready while idle");
   chk_last_count: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE4]
      state_q == awp_pkg::AWP_LASTBEAT |-> left_q == `AWP_LEN_W'(0))
      else $error("last beat entered early");
   chk_lane_top: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE11]
      wFire && clkEn |=> memBitEn[31:24] == {8{$past(wStrb[3])}}) else $error("lane 3 mask");

   cov_single: cover property (@(posedge clk_sys) awFire && awLen == 8'h00);
   cov_wrap: cover property (@(posedge clk_sys) awFire && awBurst == `AWP_BURST_WRAP);
   cov_done: cover property (@(posedge clk_sys) burstDone);
   cov_stall: cover property (@(posedge clk_sys)
      state_q == awp_pkg::AWP_BURST && wReady && !wValid);
endmodule
`default_nettype wire

// ===== test/awp_master_model.sv
// Behavioural bus master feeding write addresses and data beats to the port
`timescale 1ns/1ps
`default_nettype none
module awp_master_model (
   input  wire logic        clk_sys,
   input  wire logic        awReady,
   input  wire logic        wReady,
   output logic [3:0]       awId,
   output logic [31:0]      awAddr,
   output logic [7:0]       awLen,
   output logic [2:0]       awSize,
   output logic [1:0]       awBurst,
   output logic [2:0]       awLock,
   output logic [4:0]       awCache,
   output logic [3:0]       awProt,
   output logic             awValid,
   output logic [31:0]      wData,
   output logic [3:0]       wStrb,
   output logic             wValid
);
   initial {awValid, wValid, awId, awAddr, awLen, awSize, awBurst, wData, wStrb} = 0;
   initial {awLock, awCache, awProt} = 0;
   // Released lines carry the inverse of their last value so a stale value never matches
   task automatic quiet();
      {awValid, wValid} = 2'h0;
      {awId, awAddr, awLen, awSize, awBurst} = ~{awId, awAddr, awLen, awSize, awBurst};
      {wData, wStrb} = ~{wData, wStrb};
   endtask
   task automatic send(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s,
      input logic [1:0] b, input logic [3:0] id, input int stall);
      int t = 0;
      @(negedge clk_sys);
      {awId, awAddr, awLen, awSize, awBurst, awValid} = {id, a, l, s, b, 1'b1};
      {awLock, awCache, awProt} = {id[2:0], ~id, 1'b1, id};
      do @(posedge clk_sys); while (awReady !== 1'b1 && ++t < 300);
      for (int k = 0; k <= int'(l); k++)
      begin
         @(negedge clk_sys);
         if (k == 0 || stall > 0)
            quiet();
         repeat (stall) @(negedge clk_sys);
         {wData, wStrb, wValid} = {~a ^ (32'(k) * 32'h0101_0101), 4'(k * 5 + 3), 1'b1};
         do @(posedge clk_sys); while (wReady !== 1'b1 && ++t < 300);
      end
      @(negedge clk_sys);
      quiet();
   endtask
endmodule
`default_nettype wire

// ===== test/axi_ram_write_address_port_tb_top.sv
// Self-checking bench for the write address port driven by a master model
`timescale 1ns/1ps
`default_nettype none
`include "awp_defines.svh"
module axi_ram_write_address_port_tb_top;
   logic        clk_sys, reset, aresetN, clkEn, awValid, wValid, awReady, wReady, memWe;
   logic        burstDone, eccInterrupt, uncorrectable_error_flag;
   logic [31:0] awAddr, wData, memAddr, memData, memBitEn;
   logic [7:0]  awLen;
   logic [4:0]  awCache;
   logic [3:0]  awId, awProt, wStrb, doneId;
   logic [2:0]  awSize, awLock;
   logic [1:0]  awBurst;
   int          errors = 0;
   int          numChecks = 0;
   awp_write_port dut (.clk_sys, .reset, .clkEn, .aresetN, .awId, .awAddr, .awLen,
      .awSize, .awBurst, .awLock, .awCache, .awProt, .awValid, .wData, .wStrb, .wValid,
      .awReady, .wReady, .memWe, .memAddr, .memData, .memBitEn, .burstDone, .doneId,
      .eccInterrupt, .uncorrectable_error_flag);
   awp_master_model master (.clk_sys, .awReady, .wReady, .awId, .awAddr, .awLen, .awSize,
      .awBurst, .awLock, .awCache, .awProt, .awValid, .wData, .wStrb, .wValid);
   initial clk_sys = 1'b0;
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      errors += int'(got !== exp);
      if (got !== exp)
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
   endtask
   task automatic finish_test();
      $display("%0d checks, %0d mismatches", numChecks, errors);
      if (errors == 0 && numChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      errors++;
      finish_test();
   end
   // Outputs are judged on the falling edge, where the registered values have settled
   task automatic run_burst(input string nm, input logic [31:0] a, input logic [7:0] l,
      input logic [2:0] s, input logic [1:0] b, input logic [3:0] id, input int stall);
      logic [31:0] st, blk, ea, be;
      logic [3:0]  sb;
      int          t = 0;
      st = 32'h1 << s;
      blk = (32'(l) + 32'h1) << s;
      fork
         master.send(a, l, s, b, id, stall);
      join_none
      for (int k = 0; k <= int'(l); k++)
      begin
         do @(negedge clk_sys); while (memWe !== 1'b1 && ++t < 300);
         sb = 4'(k * 5 + 3);
         be = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
         // FIXED steps like INCR; WRAP stays inside its (len+1)<<size block
         ea = (b === `AWP_BURST_WRAP) ? (a & ~(blk - 1)) | ((a + 32'(k) * st) & (blk - 1))
                                      : a + 32'(k) * st;
         check({nm, " write"}, 32'(memWe), 32'h1);
         check({nm, " addr"}, memAddr, ea);
         check({nm, " data"}, memData, ~a ^ (32'(k) * 32'h0101_0101));
         check({nm, " lanes"}, memBitEn, be);
         check({nm, " last"}, 32'(burstDone), 32'(k == l));
         check({nm, " aw ready"}, 32'(awReady), 32'(k == l));
         check({nm, " w ready"}, 32'(wReady), 32'(k != l));
      end
      check({nm, " id"}, 32'(doneId), 32'(id));
      @(negedge clk_sys);
      check({nm, " extra"}, 32'({memWe, burstDone}), 32'h0);
      check({nm, " ecc irq"}, 32'(eccInterrupt), 32'h0);
      check({nm, " ecc flag"}, 32'(uncorrectable_error_flag), 32'h0);
      wait fork;
      $display("test %s done", nm);
   endtask
   initial
   begin
      reset = 1'b1;
      aresetN = 1'b1;
      clkEn = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("aw ready in reset", 32'(awReady), 32'h0);
      reset = 1'b0;
      run_burst("incr", 32'h0000_1000, 8'h03, 3'h2, `AWP_BURST_INCR, 4'h1, 0);
      run_burst("wrap", 32'h0000_1008, 8'h03, 3'h2, `AWP_BURST_WRAP, 4'h2, 1);
      run_burst("fixed", 32'h0000_2002, 8'h02, 3'h1, `AWP_BURST_FIXED, 4'h4, 0);
      run_burst("single", 32'h0000_0301, 8'h00, 3'h0, `AWP_BURST_INCR, 4'hE, 2);
      fork
         master.send(32'h0000_0040, 8'h07, 3'h2, `AWP_BURST_INCR, 4'h3, 0);
      join_none
      repeat (4) @(negedge clk_sys);
      aresetN = 1'b0;
      @(negedge clk_sys);
      check("aw ready in bus reset", 32'(awReady), 32'h0);
      check("write in bus reset", 32'({wReady, memWe, burstDone}), 32'h0);
      disable fork;
      master.quiet();
      // Release with the enable low: ready must wait for the first enabled edge
      clkEn = 1'b0;
      aresetN = 1'b1;
      repeat (2) @(negedge clk_sys);
      check("aw ready frozen", 32'(awReady), 32'h0);
      clkEn = 1'b1;
      @(negedge clk_sys);
      check("aw ready after reset", 32'(awReady), 32'h1);
      $display("test bus reset done");
      run_burst("long", 32'h0000_3000, 8'h0F, 3'h2, `AWP_BURST_INCR, 4'h9, 0);
      finish_test();
   end
endmodule
`default_nettype wire
